//--- core/ufc_pkg.sv
// Shared constants, register map and helper functions of the UART flow-control feature block.
package ufc_pkg;

  typedef logic [7:0] ufc_byte_t;

  // ----------------------------------------------------------------
  // Register byte addresses on the APB port
  // ----------------------------------------------------------------
  localparam logic [11:0] UFC_OFF_FEATURE = 12'h000;
  localparam logic [11:0] UFC_OFF_ENHANCED = 12'h004;
  localparam logic [11:0] UFC_OFF_MODEM_CTL = 12'h008;
  localparam logic [11:0] UFC_OFF_INT_EN = 12'h00c;
  localparam logic [11:0] UFC_OFF_FIFO_CTL = 12'h010;
  localparam logic [11:0] UFC_OFF_MODEM_ST = 12'h014;
  localparam logic [11:0] UFC_OFF_RESUME1 = 12'h018;
  localparam logic [11:0] UFC_OFF_RESUME2 = 12'h01c;
  localparam logic [11:0] UFC_OFF_PAUSE1 = 12'h020;
  localparam logic [11:0] UFC_OFF_PAUSE2 = 12'h024;
  localparam logic [11:0] UFC_OFF_RX_TRIG = 12'h028;
  localparam logic [11:0] UFC_OFF_STATUS = 12'h02c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned FC_IR_POL = 4;
  localparam int unsigned FC_TBL_LSB = 6;
  localparam int unsigned EF_AUTO_CTS = 7;
  localparam int unsigned EF_AUTO_RTS = 6;
  localparam int unsigned EF_SPECIAL = 5;
  localparam int unsigned EF_ENH = 4;
  localparam int unsigned EF_TX_LSB = 2;
  localparam int unsigned MC_DTR = 0;
  localparam int unsigned MC_RTS = 1;
  localparam int unsigned MC_FLOW_SEL = 2;
  localparam int unsigned ST_XOFF = 0;
  localparam int unsigned ST_XON = 1;
  localparam int unsigned ST_SPECIAL = 4;
  localparam int unsigned ST_PAUSED = 5;
  localparam int unsigned ST_TRIG = 6;
  localparam int unsigned ST_HALT = 7;
  localparam ufc_byte_t UFC_RST_BYTE = 8'h00;
  localparam ufc_byte_t ST_STICKY_MASK = 8'h13;

  // Bits that only change while the enhanced-function enable is set.
  localparam ufc_byte_t IER_PROT = 8'he0;
  localparam ufc_byte_t FCR_PROT = 8'h30;
  localparam ufc_byte_t MCR_PROT = 8'hec;
  localparam ufc_byte_t MSR_PROT = 8'hfc;

  localparam logic [1:0] TBL_D = 2'b11;
  localparam logic [1:0] SW_NONE = 2'b00;
  localparam logic [1:0] SW_FIRST = 2'b10;
  localparam logic [1:0] SW_SECOND = 2'b01;
  localparam logic [1:0] SW_DUAL = 2'b11;

  typedef enum logic [1:0] {
    UFC_TX_IDLE = 2'b00,
    UFC_TX_FIRST = 2'b01,
    UFC_TX_SECOND = 2'b10
  } ufc_txseq_t;

  // Hysteresis code to character offset around the receive trigger.
  function automatic ufc_byte_t ufc_hyst_chars(input logic [3:0] code);
    case (code)
      4'h0: ufc_hyst_chars = 8'h00;
      4'h1: ufc_hyst_chars = 8'h04;
      4'h2: ufc_hyst_chars = 8'h06;
      4'h3: ufc_hyst_chars = 8'h08;
      4'h4: ufc_hyst_chars = 8'h08;
      4'h5: ufc_hyst_chars = 8'h10;
      4'h6: ufc_hyst_chars = 8'h18;
      4'h7: ufc_hyst_chars = 8'h20;
      4'h8: ufc_hyst_chars = 8'h28;
      4'h9: ufc_hyst_chars = 8'h2c;
      4'ha: ufc_hyst_chars = 8'h30;
      4'hb: ufc_hyst_chars = 8'h34;
      4'hc: ufc_hyst_chars = 8'h0c;
      4'hd: ufc_hyst_chars = 8'h14;
      4'he: ufc_hyst_chars = 8'h1c;
      default: ufc_hyst_chars = 8'h24;
    endcase
  endfunction

  // Write merge that keeps protected bits while the enable is clear.
  function automatic ufc_byte_t ufc_protect(input ufc_byte_t old_v, input ufc_byte_t new_v,
                                            input ufc_byte_t mask, input logic en);
    ufc_protect = en ? new_v : ((old_v & mask) | (new_v & ~mask));
  endfunction

endpackage

//--- core/ufc_hyst.sv
// Receive fill watermark with hysteresis that drives the hardware flow-control level.
`timescale 1ns/1ps
`default_nettype none
module ufc_hyst
  import ufc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire ufc_pkg::ufc_byte_t i_fill,
  input wire ufc_pkg::ufc_byte_t i_trig,
  input wire logic [1:0] i_table,
  input wire logic [3:0] i_hyst_code,
  input wire ufc_pkg::ufc_byte_t i_next_upper,
  input wire ufc_pkg::ufc_byte_t i_next_lower,
  output logic o_over,
  output logic o_reached
);

  // Code zero keeps next-level behaviour even under table D.
  wire ufc_byte_t hyst = ufc_hyst_chars(i_hyst_code);
  wire use_hyst = (i_table == TBL_D) && (hyst != UFC_RST_BYTE);
  wire [8:0] up_sum = {1'b0, i_trig} + {1'b0, hyst};
  wire ufc_byte_t up_hyst = up_sum[8] ? 8'hff : up_sum[7:0];
  wire ufc_byte_t low_hyst = (i_trig > hyst) ? (i_trig - hyst) : UFC_RST_BYTE;
  // Under table D with a nonzero code, upper and lower thresholds are referenced to the receive trigger.
  wire ufc_byte_t upper = use_hyst ? up_hyst : i_next_upper;
  wire ufc_byte_t lower = use_hyst ? low_hyst : i_next_lower;
  wire over_nxt = (i_fill >= upper) ? 1'b1 : ((i_fill < lower) ? 1'b0 : o_over);

  // The gap between thresholds stops the flow pin chattering on each character.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_over <= 1'b0;
      o_reached <= 1'b0;
    end
    else
    begin
      o_over <= over_nxt;
      o_reached <= (i_fill >= i_trig);
    end
  end

endmodule
`default_nettype wire

//--- core/ufc_rx_match.sv
// Receive comparator for pause, resume and special characters.
`timescale 1ns/1ps
`default_nettype none
module ufc_rx_match
  import ufc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire ufc_pkg::ufc_byte_t i_char,
  input wire logic [1:0] i_rx_mode,
  input wire logic [1:0] i_tx_mode,
  input wire logic i_special_en,
  input wire ufc_pkg::ufc_byte_t i_resume1,
  input wire ufc_pkg::ufc_byte_t i_resume2,
  input wire ufc_pkg::ufc_byte_t i_pause1,
  input wire ufc_pkg::ufc_byte_t i_pause2,
  output logic o_store,
  output ufc_pkg::ufc_byte_t o_store_char,
  output logic o_xon,
  output logic o_xoff,
  output logic o_special
);

  logic pend_on_r;
  logic pend_off_r;

  // Mode decode: either single character, or the two-character sequence.
  wire either = (i_rx_mode == SW_DUAL) && ((i_tx_mode == SW_FIRST) || (i_tx_mode == SW_SECOND));
  wire dual = (i_rx_mode == SW_DUAL) && !either;
  wire cmp1 = (i_rx_mode == SW_FIRST) || either;
  wire cmp2 = (i_rx_mode == SW_SECOND) || either;
  // Whole-byte equality keeps bit 0 against the received LSB.
  wire eq_on1 = (i_char == i_resume1);
  wire eq_on2 = (i_char == i_resume2);
  wire eq_off1 = (i_char == i_pause1);
  wire eq_off2 = (i_char == i_pause2);
  wire single_on = (cmp1 && eq_on1) || (cmp2 && eq_on2);
  wire single_off = (cmp1 && eq_off1) || (cmp2 && eq_off2);
  // A pending first character only completes on the very next character.
  wire dual_on = dual && pend_on_r && eq_on2;
  wire dual_off = dual && pend_off_r && eq_off2;
  wire special = i_special_en && eq_off2;

  // Single control characters are consumed; sequence characters still reach the FIFO.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pend_on_r <= 1'b0;
      pend_off_r <= 1'b0;
      o_store <= 1'b0;
      o_store_char <= UFC_RST_BYTE;
      o_xon <= 1'b0;
      o_xoff <= 1'b0;
      o_special <= 1'b0;
    end
    else
    begin
      o_store <= i_valid && !single_on && !single_off;
      o_xon <= i_valid && (single_on || dual_on);
      o_xoff <= i_valid && (single_off || dual_off);
      o_special <= i_valid && special;
      if (i_valid)
      begin
        o_store_char <= i_char;
        pend_on_r <= dual && eq_on1;
        pend_off_r <= dual && eq_off1;
      end
      else if (!dual)
      begin
        pend_on_r <= 1'b0;
        pend_off_r <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

//--- core/ufc_top.sv
// Enhanced flow-control features of one UART channel behind an APB register port.
`timescale 1ns/1ps
`default_nettype none
module ufc_top
  import ufc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_irda_rx,
  input wire logic i_cts_n,
  input wire logic i_dsr_n,
  output logic o_rts_n,
  output logic o_dtr_n,
  output logic o_irda_rx_data,
  input wire logic i_rx_valid,
  input wire ufc_pkg::ufc_byte_t i_rx_char,
  input wire ufc_pkg::ufc_byte_t i_rx_fill,
  input wire ufc_pkg::ufc_byte_t i_next_upper,
  input wire ufc_pkg::ufc_byte_t i_next_lower,
  input wire logic i_tx_busy,
  input wire logic i_send_pause,
  input wire logic i_send_resume,
  input wire logic i_ctl_ready,
  output logic o_ctl_valid,
  output ufc_pkg::ufc_byte_t o_ctl_char,
  output logic o_tx_halt,
  output logic o_rx_store,
  output ufc_pkg::ufc_byte_t o_rx_store_char,
  output logic o_rx_trig_irq,
  output logic o_special_irq,
  output logic o_xoff_irq,
  output ufc_pkg::ufc_byte_t o_interrupt_enable,
  output ufc_pkg::ufc_byte_t o_fifo_control,
  output ufc_pkg::ufc_byte_t o_modem_status_wr
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  ufc_byte_t feature_control_r;
  ufc_byte_t enhanced_feature_r;
  ufc_byte_t modem_control_r;
  ufc_byte_t first_resume_char_r;
  ufc_byte_t second_resume_char_r;
  ufc_byte_t first_pause_char_r;
  ufc_byte_t second_pause_char_r;
  ufc_byte_t rx_trig_r;
  ufc_byte_t status_r;
  ufc_byte_t status_nxt;
  ufc_byte_t rd_byte;
  logic rd_hit;
  logic remote_paused_r;
  ufc_txseq_t txseq_r;
  ufc_txseq_t txseq_nxt;
  logic ctl_pause_r;
  logic over;
  logic reached;
  logic m_store;
  ufc_byte_t m_store_char;
  logic m_xon;
  logic m_xoff;
  logic m_special;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Data is registered in the setup cycle, so each access takes exactly two cycles.
  wire setup = i_psel && !i_penable;
  wire done = i_psel && i_penable && o_pready;
  wire wr_go = done && i_pwrite && i_pstrb[0];
  wire rd_go = done && !i_pwrite;
  wire enh_en = enhanced_feature_r[EF_ENH];
  wire ufc_byte_t wbyte = i_pwdata[7:0];
  wire [1:0] tx_mode = enhanced_feature_r[EF_TX_LSB +: 2];
  wire [1:0] rx_mode = enhanced_feature_r[1:0];

  // Read mux; unmapped addresses read zero and answer with an error.
  always_comb
  begin
    rd_hit = 1'b1;
    rd_byte = UFC_RST_BYTE;
    if (i_paddr == UFC_OFF_FEATURE)
      rd_byte = feature_control_r;
    else if (i_paddr == UFC_OFF_ENHANCED)
      rd_byte = enhanced_feature_r;
    else if (i_paddr == UFC_OFF_MODEM_CTL)
      rd_byte = modem_control_r;
    else if (i_paddr == UFC_OFF_INT_EN)
      rd_byte = o_interrupt_enable;
    else if (i_paddr == UFC_OFF_FIFO_CTL)
      rd_byte = o_fifo_control;
    else if (i_paddr == UFC_OFF_MODEM_ST)
      rd_byte = o_modem_status_wr;
    else if (i_paddr == UFC_OFF_RESUME1)
      rd_byte = first_resume_char_r;
    else if (i_paddr == UFC_OFF_RESUME2)
      rd_byte = second_resume_char_r;
    else if (i_paddr == UFC_OFF_PAUSE1)
      rd_byte = first_pause_char_r;
    else if (i_paddr == UFC_OFF_PAUSE2)
      rd_byte = second_pause_char_r;
    else if (i_paddr == UFC_OFF_RX_TRIG)
      rd_byte = rx_trig_r;
    else if (i_paddr == UFC_OFF_STATUS)
      rd_byte = status_r;
    else
      rd_hit = 1'b0;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end
    else
    begin
      o_pready <= setup;
      if (setup)
      begin
        o_pslverr <= !rd_hit;
        o_prdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  // Everything resets to zero so the channel starts in legacy-compatible mode.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      feature_control_r <= UFC_RST_BYTE;
      enhanced_feature_r <= UFC_RST_BYTE;
      modem_control_r <= UFC_RST_BYTE;
      o_interrupt_enable <= UFC_RST_BYTE;
      o_fifo_control <= UFC_RST_BYTE;
      o_modem_status_wr <= UFC_RST_BYTE;
      first_resume_char_r <= UFC_RST_BYTE;
      second_resume_char_r <= UFC_RST_BYTE;
      first_pause_char_r <= UFC_RST_BYTE;
      second_pause_char_r <= UFC_RST_BYTE;
      rx_trig_r <= UFC_RST_BYTE;
    end
    else if (wr_go)
    begin
      if (i_paddr == UFC_OFF_FEATURE)
        feature_control_r <= wbyte;
      else if (i_paddr == UFC_OFF_ENHANCED)
        enhanced_feature_r <= wbyte;
      else if (i_paddr == UFC_OFF_MODEM_CTL)
        modem_control_r <= ufc_protect(modem_control_r, wbyte, MCR_PROT, enh_en);
      else if (i_paddr == UFC_OFF_INT_EN)
        o_interrupt_enable <= ufc_protect(o_interrupt_enable, wbyte, IER_PROT, enh_en);
      else if (i_paddr == UFC_OFF_FIFO_CTL)
        o_fifo_control <= ufc_protect(o_fifo_control, wbyte, FCR_PROT, enh_en);
      else if (i_paddr == UFC_OFF_MODEM_ST)
        o_modem_status_wr <= ufc_protect(o_modem_status_wr, wbyte, MSR_PROT, enh_en);
      else if (i_paddr == UFC_OFF_RESUME1)
        first_resume_char_r <= wbyte;
      else if (i_paddr == UFC_OFF_RESUME2)
        second_resume_char_r <= wbyte;
      else if (i_paddr == UFC_OFF_PAUSE1)
        first_pause_char_r <= wbyte;
      else if (i_paddr == UFC_OFF_PAUSE2)
        second_pause_char_r <= wbyte;
      else if (i_paddr == UFC_OFF_RX_TRIG)
        rx_trig_r <= wbyte;
    end
  end

  // ----------------------------------------------------------------
  // Receive side: watermark and character comparison
  // ----------------------------------------------------------------
  ufc_hyst u_hyst (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_fill(i_rx_fill),
    .i_trig(rx_trig_r),
    .i_table(feature_control_r[FC_TBL_LSB +: 2]),
    .i_hyst_code(feature_control_r[3:0]),
    .i_next_upper(i_next_upper),
    .i_next_lower(i_next_lower),
    .o_over(over),
    .o_reached(reached)
  );

  ufc_rx_match u_match (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_valid(i_rx_valid),
    .i_char(i_rx_char),
    .i_rx_mode(rx_mode),
    .i_tx_mode(tx_mode),
    .i_special_en(enhanced_feature_r[EF_SPECIAL]),
    .i_resume1(first_resume_char_r),
    .i_resume2(second_resume_char_r),
    .i_pause1(first_pause_char_r),
    .i_pause2(second_pause_char_r),
    .o_store(m_store),
    .o_store_char(m_store_char),
    .o_xon(m_xon),
    .o_xoff(m_xoff),
    .o_special(m_special)
  );

  // ----------------------------------------------------------------
  // Modem pins and transmit halt
  // ----------------------------------------------------------------
  // Flow pin follows the watermark only once software has asserted it.
  wire sel_dtr = modem_control_r[MC_FLOW_SEL];
  wire sw_assert = sel_dtr ? modem_control_r[MC_DTR] : modem_control_r[MC_RTS];
  wire auto_pin = sw_assert ? over : 1'b1;
  wire flow_pin = enhanced_feature_r[EF_AUTO_RTS] ? auto_pin : !sw_assert;
  wire rts_n_nxt = sel_dtr ? !modem_control_r[MC_RTS] : flow_pin;
  wire dtr_n_nxt = sel_dtr ? flow_pin : !modem_control_r[MC_DTR];
  wire stop_in = sel_dtr ? i_dsr_n : i_cts_n;
  wire halt_want = (enhanced_feature_r[EF_AUTO_CTS] && stop_in) || remote_paused_r;
  // Halt changes only between characters, so a character on the wire always completes.
  wire halt_nxt = i_tx_busy ? o_tx_halt : halt_want;
  wire paused_nxt = (rx_mode == SW_NONE) ? 1'b0 : (m_xoff ? 1'b1 : (m_xon ? 1'b0 : remote_paused_r));

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rts_n <= 1'b1;
      o_dtr_n <= 1'b1;
      o_tx_halt <= 1'b0;
      remote_paused_r <= 1'b0;
      o_irda_rx_data <= 1'b0;
    end
    else
    begin
      o_rts_n <= rts_n_nxt;
      o_dtr_n <= dtr_n_nxt;
      o_tx_halt <= halt_nxt;
      remote_paused_r <= paused_nxt;
      o_irda_rx_data <= i_irda_rx ^ feature_control_r[FC_IR_POL];
    end
  end

  // ----------------------------------------------------------------
  // Status flags and event outputs
  // ----------------------------------------------------------------
  // Only bits actually returned by the read are cleared, and a new event beats the clear.
  wire ufc_byte_t st_clr = rd_go && (i_paddr == UFC_OFF_STATUS) ? (o_prdata[7:0] & ST_STICKY_MASK) : UFC_RST_BYTE;

  always_comb
  begin
    status_nxt = status_r & ~st_clr;
    status_nxt[ST_XOFF] = status_nxt[ST_XOFF] | m_xoff;
    status_nxt[ST_XON] = status_nxt[ST_XON] | m_xon;
    status_nxt[ST_SPECIAL] = status_nxt[ST_SPECIAL] | m_special;
    status_nxt[ST_PAUSED] = remote_paused_r;
    status_nxt[ST_TRIG] = reached;
    status_nxt[ST_HALT] = o_tx_halt;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      status_r <= UFC_RST_BYTE;
      o_rx_store <= 1'b0;
      o_rx_store_char <= UFC_RST_BYTE;
      o_rx_trig_irq <= 1'b0;
      o_special_irq <= 1'b0;
      o_xoff_irq <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      o_rx_store <= m_store;
      o_rx_store_char <= m_store_char;
      o_rx_trig_irq <= reached;
      o_special_irq <= status_r[ST_SPECIAL];
      o_xoff_irq <= status_r[ST_XOFF];
    end
  end

  // ----------------------------------------------------------------
  // Transmit control-character sequencer
  // ----------------------------------------------------------------
  // Requests that arrive while a sequence is still pending are dropped.
  wire tx_req = (i_send_pause || i_send_resume) && (tx_mode != SW_NONE);
  wire pick_pause = i_send_pause;
  wire ufc_byte_t first_of = pick_pause ? first_pause_char_r : first_resume_char_r;
  wire ufc_byte_t second_of = ctl_pause_r ? second_pause_char_r : second_resume_char_r;
  wire ufc_byte_t single_of = (tx_mode == SW_SECOND) ?
                              (pick_pause ? second_pause_char_r : second_resume_char_r) : first_of;
  wire accept = o_ctl_valid && i_ctl_ready;

  always_comb
  begin
    txseq_nxt = txseq_r;
    case (txseq_r)
      UFC_TX_IDLE:
        if (tx_req)
          txseq_nxt = UFC_TX_FIRST;
      UFC_TX_FIRST:
        if (accept)
          txseq_nxt = (tx_mode == SW_DUAL) ? UFC_TX_SECOND : UFC_TX_IDLE;
      UFC_TX_SECOND:
        if (accept)
          txseq_nxt = UFC_TX_IDLE;
      default:
        txseq_nxt = UFC_TX_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      txseq_r <= UFC_TX_IDLE;
      ctl_pause_r <= 1'b0;
      o_ctl_valid <= 1'b0;
      o_ctl_char <= UFC_RST_BYTE;
    end
    else
    begin
      txseq_r <= txseq_nxt;
      o_ctl_valid <= (txseq_nxt != UFC_TX_IDLE);
      if ((txseq_r == UFC_TX_IDLE) && tx_req)
      begin
        ctl_pause_r <= pick_pause;
        o_ctl_char <= single_of;
      end
      else if ((txseq_r == UFC_TX_FIRST) && (txseq_nxt == UFC_TX_SECOND))
        o_ctl_char <= second_of;
    end
  end

endmodule
`default_nettype wire

//--- dv/ufc_chk.sv
// Port assertions of the flow-control feature block.
`timescale 1ns/1ps
`default_nettype none
module ufc_chk
  import ufc_pkg::*;
(
  input wire logic i_sys_clk, i_rst_n, i_psel, i_penable, o_pready, o_pslverr,
  input wire logic [11:0] i_paddr,
  input wire logic i_tx_busy, o_tx_halt, i_rx_valid, o_rx_store, o_xoff_irq, o_special_irq,
  input wire logic o_ctl_valid, i_ctl_ready,
  input wire ufc_pkg::ufc_byte_t i_rx_char, o_rx_store_char
);
  // ----
  // Bus timing, receive path and control-character handshake.
  // ----
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence setup_s;
    i_psel && !i_penable;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> o_pready) else $error("no ready after setup");
  ready_single_a: assert property (o_pready |=> !o_pready) else $error("ready held too long");
  unmapped_err_a: assert property (setup_s ##0 (i_paddr > 12'h02c) |=> o_pslverr) else $error("no error");
  halt_hold_a: assert property (i_tx_busy |=> $stable(o_tx_halt)) else $error("halt moved");
  store_char_a: assert property (o_rx_store |-> $past(i_rx_valid, 2) && o_rx_store_char == $past(i_rx_char, 2))
    else $error("stored character wrong");
  xoff_late_a: assert property ($rose(o_xoff_irq) |-> $past(i_rx_valid, 3)) else $error("stray xoff");
  special_late_a: assert property ($rose(o_special_irq) |-> $past(i_rx_valid, 3)) else $error("stray special");
  ctl_hold_a: assert property (o_ctl_valid && !i_ctl_ready |=> o_ctl_valid) else $error("ctl dropped");
endmodule
bind ufc_top ufc_chk u_chk (.*);
`default_nettype wire

//--- dv/ufc_remote.sv
// Behavioural remote serial device on the modem pins and receive path.
`timescale 1ns/1ps
`default_nettype none
module ufc_remote (
  input wire logic i_sys_clk,
  output logic o_cts_n = 1'b0, o_dsr_n = 1'b0, o_rx_valid = 1'b0, o_ctl_ready = 1'b1,
  output ufc_pkg::ufc_byte_t o_rx_char = 8'h5a
);
  logic stall = 1'b0;
  // Ready drops while asked to stall, so held requests are exercised.
  always @(posedge i_sys_clk) o_ctl_ready <= !stall;
  task automatic modem(input logic c, input logic d);
    @(posedge i_sys_clk);
    o_cts_n <= c;
    o_dsr_n <= d;
  endtask
  // Released data shows the inverse so a stale value never matches.
  task automatic send(input ufc_pkg::ufc_byte_t c);
    @(posedge i_sys_clk);
    o_rx_valid <= 1'b1;
    o_rx_char <= c;
    @(posedge i_sys_clk);
    o_rx_valid <= 1'b0;
    o_rx_char <= ~c;
    @(posedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking testbench of the flow-control feature block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ufc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irda = 1'b0, busy = 1'b0, sp = 1'b0;
  logic pready, pslverr, cts_n, dsr_n, rts_n, irq_d, rxv, cv, crdy, halt, store, dtr_n, trq, spq, xoq;
  logic sr = 1'b0;
  logic [3:0] strb = 4'hf;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  ufc_byte_t fill = 8'h00, rdv, rxc, cch, sc, ien, fifo_control, modem_status;
  logic [3:0] hc[2] = '{4'h1, 4'h8};
  ufc_byte_t ho[2] = '{8'h04, 8'h28}, tm[3] = '{8'h18, 8'h14, 8'h1c}, c0[3] = '{8'h13, 8'ha5, 8'h13};
  ufc_byte_t sent[$];
  int mismatches = 0, compares = 0, stores = 0, st;
  ufc_top dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(strb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_irda_rx(irda), .i_cts_n(cts_n), .i_dsr_n(dsr_n), .o_rts_n(rts_n), .o_dtr_n(dtr_n), .o_irda_rx_data(irq_d),
    .i_rx_valid(rxv), .i_rx_char(rxc), .i_rx_fill(fill), .i_next_upper(8'h50), .i_next_lower(8'h08),
    .i_tx_busy(busy), .i_send_pause(sp), .i_send_resume(sr), .i_ctl_ready(crdy), .o_ctl_valid(cv),
    .o_ctl_char(cch), .o_tx_halt(halt), .o_rx_store(store), .o_rx_store_char(sc), .o_rx_trig_irq(trq),
    .o_special_irq(spq), .o_xoff_irq(xoq), .o_interrupt_enable(ien), .o_fifo_control(fifo_control), .o_modem_status_wr(modem_status));
  ufc_remote rem (.i_sys_clk(clk), .o_cts_n(cts_n), .o_dsr_n(dsr_n), .o_rx_valid(rxv), .o_rx_char(rxc),
    .o_ctl_ready(crdy));
  always #10 clk = ~clk;
  // Accepted control characters are logged and stored receive characters are counted.
  always @(posedge clk) if (cv === 1'b1 && crdy) sent.push_back(cch);
  always @(posedge clk) if (store === 1'b1) stores++;
  task automatic apb(input logic w, input logic [11:0] a, input ufc_byte_t d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata[7:0];
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic cmp(input string nm, input ufc_byte_t e, input ufc_byte_t g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk(input logic [11:0] a, input ufc_byte_t e, input ufc_byte_t m);
    apb(1'b0, a, 8'h00);
    cmp($sformatf("reg %h", a), e, rdv & m);
  endtask
  // Pins are sampled three edges on, past the two-edge flow latency.
  task automatic pin(input ufc_byte_t f, input logic e);
    fill <= f;
    repeat (3) @(posedge clk);
    cmp("rts", {7'h0, e}, {7'h0, rts_n});
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #200us;
    mismatches++;
    finish_test();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(UFC_OFF_ENHANCED, 8'h00, 8'hff);
    apb(1'b0, 12'h030, 8'h00);
    cmp("slverr", 8'h01, {7'h0, pslverr});
    apb(1'b1, UFC_OFF_INT_EN, 8'hff);
    chk(UFC_OFF_INT_EN, 8'h1f, 8'hff);
    apb(1'b1, UFC_OFF_FIFO_CTL, 8'hff);
    apb(1'b1, UFC_OFF_MODEM_ST, 8'hff);
    strb <= 4'h0;
    apb(1'b1, UFC_OFF_FIFO_CTL, 8'h00);
    strb <= 4'hf;
    cmp("fcr", 8'hcf, fifo_control);
    cmp("msr", 8'h03, modem_status);
    apb(1'b1, UFC_OFF_ENHANCED, 8'h10);
    apb(1'b1, UFC_OFF_INT_EN, 8'hff);
    apb(1'b1, UFC_OFF_ENHANCED, 8'h00);
    apb(1'b1, UFC_OFF_INT_EN, 8'h00);
    chk(UFC_OFF_INT_EN, 8'he0, 8'hff);
    cmp("ien", 8'he0, ien);
    irda <= 1'b1;
    apb(1'b1, UFC_OFF_FEATURE, 8'h10);
    @(posedge clk);
    cmp("irda", 8'h00, {7'h0, irq_d});
    apb(1'b1, UFC_OFF_MODEM_CTL, 8'h02);
    @(posedge clk);
    cmp("rts", 8'h00, {7'h0, rts_n});
    cmp("dtr", 8'h01, {7'h0, dtr_n});
    $display("test registers done");
    apb(1'b1, UFC_OFF_ENHANCED, 8'h50);
    apb(1'b1, UFC_OFF_RX_TRIG, 8'h3c);
    foreach (hc[i])
    begin
      apb(1'b1, UFC_OFF_FEATURE, {4'hc, hc[i]});
      pin(8'h3b + ho[i], 1'b0);
      pin(8'h3c + ho[i], 1'b1);
      pin(8'h3c - ho[i], 1'b1);
      pin(8'h3b - ho[i], 1'b0);
    end
    apb(1'b1, UFC_OFF_FEATURE, 8'h01);
    pin(8'h40, 1'b0);
    cmp("trig", 8'h01, {7'h0, trq});
    apb(1'b1, UFC_OFF_ENHANCED, 8'h90);
    rem.modem(1'b1, 1'b0);
    @(posedge clk);
    busy <= 1'b1;
    rem.modem(1'b0, 1'b0);
    repeat (3) @(posedge clk);
    chk(UFC_OFF_STATUS, 8'h80, 8'h80);
    busy <= 1'b0;
    apb(1'b1, UFC_OFF_MODEM_CTL, 8'h06);
    rem.modem(1'b0, 1'b1);
    repeat (2) @(posedge clk);
    chk(UFC_OFF_STATUS, 8'h80, 8'h80);
    rem.modem(1'b0, 1'b0);
    $display("test hardware flow done");
    apb(1'b1, UFC_OFF_PAUSE1, 8'h13);
    apb(1'b1, UFC_OFF_PAUSE2, 8'ha5);
    foreach (tm[i])
    begin
      sent.delete();
      apb(1'b1, UFC_OFF_ENHANCED, 8'h10);
      apb(1'b1, UFC_OFF_ENHANCED, tm[i]);
      rem.stall <= 1'b1;
      sp <= 1'b1;
      @(posedge clk) sp <= 1'b0;
      repeat (4) @(posedge clk);
      rem.stall <= 1'b0;
      repeat (6) @(posedge clk);
      cmp("ctl", c0[i], sent[0]);
      if (i == 2) cmp("ctl2", 8'ha5, sent[1]);
    end
    apb(1'b1, UFC_OFF_RESUME1, 8'h11);
    apb(1'b1, UFC_OFF_RESUME2, 8'h22);
    sent.delete();
    sr <= 1'b1;
    @(posedge clk) sr <= 1'b0;
    repeat (4) @(posedge clk);
    cmp("resume", 8'h11, sent[0]);
    cmp("resume2", 8'h22, sent[1]);
    apb(1'b1, UFC_OFF_ENHANCED, 8'h10);
    apb(1'b1, UFC_OFF_ENHANCED, 8'h31);
    st = stores;
    rem.send(8'ha5);
    chk(UFC_OFF_STATUS, 8'h11, 8'h13);
    cmp("stores", 8'(st), 8'(stores));
    cmp("xoff irq", 8'h01, {7'h0, xoq});
    cmp("special irq", 8'h01, {7'h0, spq});
    apb(1'b1, UFC_OFF_ENHANCED, 8'h10);
    apb(1'b1, UFC_OFF_ENHANCED, 8'h32);
    rem.send(8'ha5);
    chk(UFC_OFF_STATUS, 8'h10, 8'h13);
    cmp("stores", 8'(st + 1), 8'(stores));
    cmp("schar", 8'ha5, sc);
    apb(1'b1, UFC_OFF_ENHANCED, 8'h10);
    apb(1'b1, UFC_OFF_ENHANCED, 8'h1f);
    rem.send(8'h13);
    rem.send(8'h77);
    rem.send(8'ha5);
    chk(UFC_OFF_STATUS, 8'h00, 8'h13);
    rem.send(8'h13);
    rem.send(8'ha5);
    chk(UFC_OFF_STATUS, 8'h01, 8'h13);
    apb(1'b1, UFC_OFF_ENHANCED, 8'h10);
    apb(1'b1, UFC_OFF_ENHANCED, 8'h1b);
    rem.send(8'ha5);
    chk(UFC_OFF_STATUS, 8'h01, 8'h13);
    $display("test software flow done");
    finish_test();
  end
endmodule
`default_nettype wire
